// ---- logic/swl_pkg.sv ----
// package of constants for the single-wire link, slave end and master end
// Overview of operation
// RULE_01 - master holds line low 480 us to reset
// RULE_02 - slave waits 15-60 us, pulls low 60-240 us
// RULE_03 - only master starts slots; slave sends presence only
// RULE_04 - 4eh stores two bytes into alarm triggers
// RULE_05 - beh sends bytes zero through eight, check last
// RULE_06 - 48h copies triggers; read slots show busy
// RULE_07 - parasite copy needs 10 ms pull-up, no traffic
// RULE_08 - 44h starts conversion; read slots show busy
// RULE_09 - conversion up to 500 ms, parasite pull-up held
// RULE_10 - b8h and power-up reload triggers; slots show busy; code reloads at once, so b8h read slots show conversion busy only
// RULE_11 - b4h read slots report supply mode
// RULE_12 - write slot starts falling, 60 us, 1 us recovery
// RULE_13 - slave samples write slot 15-60 us after fall
// RULE_14 - write one releases line within 15 us
// RULE_15 - write zero holds line low 60 us
// RULE_16 - read slot low 1 us; data valid 15 us
// RULE_17 - read slot 60 us, 1 us recovery
// RULE_18 - init low, rise, sample sum below 15 us
// RULE_19 - idle high; low over 480 us means reset
// RULE_20 - order: reset, address command, memory command, data
// RULE_21 - bytes lsb first; unknown command ignored till reset
package swl_pkg;
    // ****************************************************************
    // timing
    // ****************************************************************
    localparam int CLK_MHZ          = 50;
    localparam int RESET_US         = 480;
    localparam int PRES_WAIT_US     = 30;
    localparam int PRES_LOW_US      = 120;
    localparam int WSAMPLE_US       = 30;
    localparam int SLOT_US          = 70;
    localparam int RECOV_US         = 2;
    localparam int WONE_LOW_US      = 5;
    localparam int RINIT_US         = 2;
    localparam int RSAMPLE_US       = 12;
    localparam int PRES_SAMPLE_US   = 70;
    localparam int RESET_CYC        = RESET_US * CLK_MHZ;
    localparam int PRES_WAIT_CYC    = PRES_WAIT_US * CLK_MHZ;
    localparam int PRES_LOW_CYC     = PRES_LOW_US * CLK_MHZ;
    localparam int WSAMPLE_CYC      = WSAMPLE_US * CLK_MHZ;
    localparam int SLOT_CYC         = SLOT_US * CLK_MHZ;
    localparam int RECOV_CYC        = RECOV_US * CLK_MHZ;
    localparam int WONE_LOW_CYC     = WONE_LOW_US * CLK_MHZ;
    localparam int RINIT_CYC        = RINIT_US * CLK_MHZ;
    localparam int RSAMPLE_CYC      = RSAMPLE_US * CLK_MHZ;
    localparam int PRES_SAMPLE_CYC  = PRES_SAMPLE_US * CLK_MHZ;
    localparam int CONV_MS          = 500;
    localparam int COPY_MS          = 10;
    localparam int CONV_CYC_DEF     = CONV_MS * 1000 * CLK_MHZ;
    localparam int COPY_CYC_DEF     = COPY_MS * 1000 * CLK_MHZ;
    localparam int CNT_W            = 25;
    // ****************************************************************
    // commands and scratchpad
    // ****************************************************************
    localparam logic [7:0] CMD_WRITE_PAD = 8'h4e;
    localparam logic [7:0] CMD_READ_PAD  = 8'hbe;
    localparam logic [7:0] CMD_COPY_PAD  = 8'h48;
    localparam logic [7:0] CMD_CONVERT   = 8'h44;
    localparam logic [7:0] CMD_RELOAD    = 8'hb8;
    localparam logic [7:0] CMD_SUPPLY    = 8'hb4;
    localparam logic [3:0] OFS_ALARM_HIGH = 4'h2;
    localparam logic [3:0] OFS_ALARM_LOW  = 4'h3;
    localparam logic [3:0] OFS_CHECK      = 4'h8;
    localparam logic [7:0] NV_HIGH_RESET  = 8'h00;
    localparam logic [7:0] NV_LOW_RESET   = 8'h00;
    // ****************************************************************
    // master command port
    // ****************************************************************
    localparam logic [1:0] MREG_CTRL   = 2'h0;
    localparam logic [1:0] MREG_TXDATA = 2'h1;
    localparam logic [1:0] MREG_STATUS = 2'h2;
    localparam logic [1:0] MREG_RXDATA = 2'h3;
    localparam logic [1:0] OP_RESET    = 2'h0;
    localparam logic [1:0] OP_WBYTE    = 2'h1;
    localparam logic [1:0] OP_RBYTE    = 2'h2;
    localparam logic [1:0] OP_HOLD     = 2'h3;
    localparam int STAT_BUSY  = 0;
    localparam int STAT_PRES  = 1;
endpackage

// ---- logic/swl_if.sv ----
// interface carrying the shared data line between master and slave
`timescale 1ns/10ps
`default_nettype none
interface swl_if;
    logic m_out;
    logic m_oen;
    logic s_out;
    logic s_oen;
    logic strong_pullup;
    logic line;
    // wired and of open-drain drivers with pull-up
    assign line = (m_oen | m_out) & (s_oen | s_out);
    modport slave  (input line, output s_out, output s_oen);
    modport master (input line, output m_out, output m_oen, output strong_pullup);
endinterface
`default_nettype wire

// ---- logic/swl_slave.sv ----
// slave end: slot decoding, presence and memory commands
`timescale 1ns/10ps
`default_nettype none
module swl_slave #(
    parameter int CONV_CYC = swl_pkg::CONV_CYC_DEF,
    parameter int COPY_CYC = swl_pkg::COPY_CYC_DEF
) (
    // clock and reset
    input  wire logic        SYS_CLK,
    input  wire logic        RSTN,
    input  wire logic        CE,
    // link
    swl_if.slave             LINK,
    // user side
    input  wire logic        EXT_POWER,
    input  wire logic [7:0]  TEMP_LSB,
    input  wire logic [7:0]  TEMP_MSB,
    input  wire logic [7:0]  CHECK_BYTE,
    output logic      [7:0]  ALARM_HIGH,
    output logic      [7:0]  ALARM_LOW,
    output logic             CONV_BUSY
);
    import swl_pkg::*;
    // ****************************************************************
    // state
    // ****************************************************************
    typedef enum logic [2:0] {
        SS_IDLE = 3'b000, SS_LOW = 3'b001, SS_PWAIT = 3'b010,
        SS_PRES = 3'b011, SS_SLOT = 3'b100, SS_WREL = 3'b101
    } swl_sst_t;
    typedef enum logic [2:0] {
        PH_ADDR = 3'b000, PH_CMD = 3'b001, PH_WPAD = 3'b010,
        PH_RPAD = 3'b011, PH_STAT = 3'b100, PH_DEAD = 3'b101
    } swl_ph_t;
    typedef struct packed {
        swl_sst_t         st;
        swl_ph_t          ph;
        logic [15:0]      cnt;
        logic [7:0]       sh;
        logic [2:0]       bitn;
        logic [3:0]       byten;
        logic [7:0]       cmd;
        logic [7:0]       hi;
        logic [7:0]       lo;
        logic [7:0]       nv_hi;
        logic [7:0]       nv_lo;
        logic [CNT_W-1:0] conv_cnt;
        logic [CNT_W-1:0] copy_cnt;
        logic             drive;
        logic             loaded;
    } swl_sstate_t;
    swl_sstate_t r;
    swl_sstate_t next_r;

    // scratchpad byte the slave would send next
    function automatic logic [7:0] pad_byte(input logic [3:0] idx, input swl_sstate_t s);
        unique case (idx)
            4'h0:           pad_byte = TEMP_LSB;
            4'h1:           pad_byte = TEMP_MSB;
            OFS_ALARM_HIGH: pad_byte = s.hi;
            OFS_ALARM_LOW:  pad_byte = s.lo;
            OFS_CHECK:      pad_byte = CHECK_BYTE;
            default:        pad_byte = 8'hff;
        endcase
    endfunction

    logic       tx_bit;
    logic [7:0] pad_now;
    // bit offered in the current read slot, lsb first
    always_comb begin
        pad_now = pad_byte(r.byten, r);
        unique case (r.ph)
            PH_RPAD: tx_bit = pad_now[r.bitn]; // RULE_05 RULE_21
            PH_STAT: begin
                if (r.cmd == CMD_SUPPLY)
                    tx_bit = EXT_POWER; // RULE_11
                else if (r.cmd == CMD_COPY_PAD)
                    tx_bit = (r.copy_cnt == '0); // RULE_06
                else
                    tx_bit = (r.conv_cnt == '0); // RULE_08 RULE_10
            end
            default: tx_bit = 1'b1;
        endcase
    end

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb begin
        next_r = r;
        if (!r.loaded) begin
            next_r.hi     = r.nv_hi; // RULE_10
            next_r.lo     = r.nv_lo;
            next_r.loaded = 1'b1;
        end
        if (r.conv_cnt != '0)
            next_r.conv_cnt = r.conv_cnt - 1'b1;
        if (r.copy_cnt != '0) begin
            next_r.copy_cnt = r.copy_cnt - 1'b1;
            if (r.copy_cnt == 1) begin
                next_r.nv_hi = r.hi; // RULE_06
                next_r.nv_lo = r.lo;
            end
        end
        if (r.cnt != 16'hffff)
            next_r.cnt = r.cnt + 1'b1;
        unique case (r.st)
            SS_IDLE: begin
                next_r.cnt = '0;
                // only the master opens a slot by pulling low
                if (!LINK.line)
                    next_r.st = SS_SLOT; // RULE_03 RULE_12
            end
            SS_SLOT: begin
                // read data held from the fall for the valid window
                next_r.drive = (r.ph == PH_RPAD || r.ph == PH_STAT) && !tx_bit
                               && r.cnt < 16'(WSAMPLE_CYC); // RULE_16
                if (r.cnt == 16'(WSAMPLE_CYC)) begin
                    next_r.drive = 1'b0;
                    next_r.st    = SS_WREL;
                    next_r.sh    = {LINK.line, r.sh[7:1]}; // RULE_13 RULE_21
                    next_r.bitn  = r.bitn + 1'b1;
                    if (r.bitn == 3'h7) begin
                        unique case (r.ph)
                            PH_ADDR: next_r.ph = PH_CMD; // RULE_20
                            PH_CMD: begin
                                next_r.cmd   = {LINK.line, r.sh[7:1]};
                                next_r.byten = '0;
                                unique case ({LINK.line, r.sh[7:1]})
                                    CMD_WRITE_PAD: begin
                                        next_r.ph    = PH_WPAD;
                                        next_r.byten = OFS_ALARM_HIGH;
                                    end
                                    CMD_READ_PAD: next_r.ph = PH_RPAD;
                                    CMD_COPY_PAD: begin
                                        next_r.ph       = PH_STAT;
                                        next_r.copy_cnt = CNT_W'(COPY_CYC);
                                    end
                                    CMD_CONVERT: begin
                                        next_r.ph       = PH_STAT;
                                        next_r.conv_cnt = CNT_W'(CONV_CYC); // RULE_09
                                    end
                                    CMD_RELOAD: begin
                                        next_r.ph = PH_STAT;
                                        next_r.hi = r.nv_hi; // RULE_10
                                        next_r.lo = r.nv_lo;
                                    end
                                    CMD_SUPPLY: next_r.ph = PH_STAT;
                                    default:    next_r.ph = PH_DEAD; // RULE_21
                                endcase
                            end
                            PH_WPAD: begin
                                if (r.byten == OFS_ALARM_HIGH)
                                    next_r.hi = {LINK.line, r.sh[7:1]}; // RULE_04
                                else if (r.byten == OFS_ALARM_LOW)
                                    next_r.lo = {LINK.line, r.sh[7:1]}; // RULE_04
                                next_r.byten = r.byten + 1'b1;
                                if (r.byten == OFS_ALARM_LOW)
                                    next_r.ph = PH_DEAD;
                            end
                            PH_RPAD: begin
                                next_r.byten = r.byten + 1'b1;
                                if (r.byten == OFS_CHECK)
                                    next_r.ph = PH_DEAD; // RULE_05
                            end
                            default: next_r.ph = r.ph;
                        endcase
                    end
                end
            end
            SS_WREL: begin
                // a long low here is a reset pulse
                if (LINK.line)
                    next_r.st = SS_IDLE;
                else if (r.cnt >= 16'(RESET_CYC))
                    next_r.st = SS_LOW; // RULE_19
            end
            SS_LOW: begin
                next_r.ph   = PH_ADDR; // RULE_04 RULE_05
                next_r.bitn = '0;
                if (LINK.line) begin
                    next_r.st  = SS_PWAIT;
                    next_r.cnt = '0;
                end
            end
            SS_PWAIT: begin
                if (r.cnt == 16'(PRES_WAIT_CYC)) begin
                    next_r.st    = SS_PRES; // RULE_02
                    next_r.cnt   = '0;
                    next_r.drive = 1'b1;
                end
            end
            SS_PRES: begin
                if (r.cnt == 16'(PRES_LOW_CYC)) begin
                    next_r.drive = 1'b0; // RULE_02
                    next_r.st    = SS_IDLE;
                end
            end
            default: next_r.st = SS_IDLE;
        endcase
    end

    // ****************************************************************
    // registers
    // ****************************************************************
    // cold start: nonvolatile store at default, reload pending
    always_ff @(posedge SYS_CLK) begin
        if (!RSTN) begin
            r <= '{st: SS_IDLE, ph: PH_DEAD, nv_hi: NV_HIGH_RESET, nv_lo: NV_LOW_RESET,
                   default: '0};
        end else if (CE) begin
            r <= next_r;
        end
    end

    // open drain: enable low while pulling down
    assign LINK.s_out = 1'b0;
    assign LINK.s_oen = !r.drive;
    assign ALARM_HIGH = r.hi;
    assign ALARM_LOW  = r.lo;
    assign CONV_BUSY  = (r.conv_cnt != '0);
endmodule
`default_nettype wire

// ---- logic/swl_master.sv ----
// master end: reset, byte write/read slots, strong pull-up hold, register port
`timescale 1ns/10ps
`default_nettype none
module swl_master #(
    parameter int CONV_CYC = swl_pkg::CONV_CYC_DEF
) (
    // clock and reset
    input  wire logic        SYS_CLK,
    input  wire logic        RSTN,
    input  wire logic        CE,
    // link
    swl_if.master            LINK,
    // register port
    input  wire logic [1:0]  ADDR,
    input  wire logic [7:0]  WDATA,
    input  wire logic        WR,
    input  wire logic        RD,
    output logic      [7:0]  RDATA
);
    import swl_pkg::*;
    typedef enum logic [2:0] {
        MS_IDLE = 3'b000, MS_RST = 3'b001, MS_PRES = 3'b010,
        MS_SLOT = 3'b011, MS_REC = 3'b100, MS_HOLD = 3'b101
    } swl_mst_t;
    typedef struct packed {
        swl_mst_t         st;
        logic [1:0]       op;
        logic [CNT_W-1:0] cnt;
        logic [7:0]       tx;
        logic [7:0]       rx;
        logic [2:0]       bitn;
        logic             pres;
        logic             drive;
        logic             spu;
        logic [7:0]       rdata;
    } swl_mstate_t;
    swl_mstate_t r;
    swl_mstate_t next_r;

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb begin
        next_r     = r;
        next_r.cnt = r.cnt + 1'b1;
        // register reads answer next cycle
        if (RD) begin
            unique case (ADDR)
                MREG_STATUS: next_r.rdata = {6'h00, r.pres, r.st != MS_IDLE};
                MREG_RXDATA: next_r.rdata = r.rx;
                MREG_TXDATA: next_r.rdata = r.tx;
                default:     next_r.rdata = {6'h00, r.op};
            endcase
        end
        if (WR && ADDR == MREG_TXDATA)
            next_r.tx = WDATA;
        unique case (r.st)
            MS_IDLE: begin
                next_r.cnt = '0;
                if (WR && ADDR == MREG_CTRL) begin
                    next_r.op   = WDATA[1:0];
                    next_r.bitn = '0;
                    unique case (WDATA[1:0])
                        OP_RESET: begin
                            next_r.st    = MS_RST;
                            next_r.drive = 1'b1; // RULE_01
                            next_r.pres  = 1'b0;
                        end
                        OP_HOLD: begin
                            next_r.st  = MS_HOLD;
                            next_r.spu = 1'b1; // RULE_07 RULE_09
                        end
                        default: begin
                            next_r.st    = MS_SLOT; // RULE_03
                            next_r.drive = 1'b1;
                        end
                    endcase
                end
            end
            MS_RST: begin
                if (r.cnt == CNT_W'(RESET_CYC + RESET_CYC / 24)) begin
                    next_r.drive = 1'b0; // RULE_01
                    next_r.st    = MS_PRES;
                    next_r.cnt   = '0;
                end
            end
            MS_PRES: begin
                if (r.cnt == CNT_W'(PRES_SAMPLE_CYC))
                    next_r.pres = !LINK.line;
                if (r.cnt == CNT_W'(RESET_CYC))
                    next_r.st = MS_IDLE;
            end
            MS_SLOT: begin
                // write one releases early, write zero holds; read releases fast
                if (r.op == OP_WBYTE) begin
                    if (r.cnt == CNT_W'(r.tx[r.bitn] ? WONE_LOW_CYC : SLOT_CYC))
                        next_r.drive = 1'b0; // RULE_12 RULE_14 RULE_15 RULE_21
                end else begin
                    if (r.cnt == CNT_W'(RINIT_CYC))
                        next_r.drive = 1'b0; // RULE_16
                    if (r.cnt == CNT_W'(RSAMPLE_CYC))
                        next_r.rx = {LINK.line, r.rx[7:1]}; // RULE_18 RULE_21
                end
                if (r.cnt == CNT_W'(SLOT_CYC)) begin
                    next_r.drive = 1'b0;
                    next_r.st    = MS_REC; // RULE_17
                    next_r.cnt   = '0;
                end
            end
            MS_REC: begin
                if (r.cnt == CNT_W'(RECOV_CYC)) begin
                    next_r.cnt  = '0;
                    next_r.bitn = r.bitn + 1'b1;
                    if (r.bitn == 3'h7) begin
                        next_r.st = MS_IDLE;
                    end else begin
                        next_r.st    = MS_SLOT;
                        next_r.drive = 1'b1;
                    end
                end
            end
            MS_HOLD: begin
                // no bus activity while the pull-up powers the slave
                if (r.cnt == CNT_W'(CONV_CYC)) begin
                    next_r.spu = 1'b0; // RULE_09
                    next_r.st  = MS_IDLE;
                end
            end
            default: next_r.st = MS_IDLE;
        endcase
    end

    // ****************************************************************
    // registers
    // ****************************************************************
    always_ff @(posedge SYS_CLK) begin
        if (!RSTN) begin
            r <= '{st: MS_IDLE, default: '0};
        end else if (CE) begin
            r <= next_r;
        end
    end

    assign LINK.m_out         = 1'b0;
    assign LINK.m_oen         = !r.drive;
    assign LINK.strong_pullup = r.spu;
    assign RDATA              = r.rdata;
endmodule
`default_nettype wire

// ---- test/swl_monitor.sv ----
// line checker for the single-wire link
`timescale 1ns/10ps
`default_nettype none
module swl_monitor #(
    parameter int CONV_CYC = 400
) (
    // clock and reset
    input wire logic SYS_CLK,
    input wire logic RSTN,
    // link
    input wire logic m_oen,
    input wire logic s_oen,
    input wire logic strong_pullup,
    input wire logic line
);
    logic [15:0] ml;
    logic [15:0] mh;
    logic [15:0] mlast;
    logic [15:0] sl;
    logic [15:0] lh;
    logic [15:0] ll;
    logic [31:0] spc;
    logic        pres;
    logic        pend;
    function automatic logic [15:0] sat(input logic [15:0] v);
        return (v == 16'hffff) ? v : v + 16'h0001;
    endfunction
    // run lengths; saturate so a long idle never wraps
    always_ff @(posedge SYS_CLK) begin
        if (!RSTN) begin
            ml    <= 16'h0000;
            mh    <= 16'hffff;
            mlast <= 16'hffff;
            sl    <= 16'h0000;
            lh    <= 16'h0000;
            ll    <= 16'h0000;
            spc   <= 32'h0;
            pres  <= 1'b0;
            pend  <= 1'b0;
        end else begin
            ml  <= m_oen ? 16'h0000 : sat(ml);
            mh  <= m_oen ? sat(mh) : 16'h0000;
            sl  <= s_oen ? 16'h0000 : sat(sl);
            lh  <= line ? sat(lh) : 16'h0000;
            ll  <= line ? 16'h0000 : sat(ll);
            spc <= strong_pullup ? spc + 32'h1 : 32'h0;
            if (m_oen && ml != 16'h0000) begin
                mlast <= ml;
            end
            // a slave pull on a high line can only be presence
            if (!s_oen && sl == 16'h0000) begin
                pres <= lh != 16'h0000;
            end
            if (line && ll >= 16'd24000) begin
                pend <= 1'b1;
            end else if (!s_oen) begin
                pend <= 1'b0;
            end
        end
    end
    // ****
    // assertions
    // ****
    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (!RSTN);
    m_low_a: assert property ($rose(m_oen) |->
        (ml >= 16'd50 && ml < 16'd750) || (ml >= 16'd3000 && ml < 16'd6000) || ml >= 16'd24000)
        else $error("master low time out of range");
    slot_recov_a: assert property ($fell(m_oen) |-> mh >= 16'd50)
        else $error("slot recovery too short");
    slot_len_a: assert property ($fell(m_oen) |->
        {1'b0, mlast} + {1'b0, mh} >= 17'd3050)
        else $error("slot too short");
    pres_wait_a: assert property ($fell(s_oen) && $past(line) |->
        pend && lh >= 16'd749 && lh <= 16'd3000)
        else $error("slave pull not a timed presence");
    pres_len_a: assert property ($rose(s_oen) && pres |->
        sl >= 16'd3000 && sl <= 16'd12000)
        else $error("presence length out of range");
    read_hold_a: assert property ($rose(s_oen) && !pres |->
        sl >= 16'd749 && sl < 16'd3000)
        else $error("read zero hold out of range");
    pres_due_a: assert property (pend |-> lh <= 16'd3000)
        else $error("no presence after bus reset");
    pullup_quiet_a: assert property (strong_pullup |-> m_oen && s_oen)
        else $error("traffic during strong pull-up");
    pullup_len_a: assert property ($fell(strong_pullup) |->
        spc >= 32'(CONV_CYC) && spc <= 32'(CONV_CYC + 2))
        else $error("strong pull-up length wrong");
    reset_idle_a: assert property ($rose(RSTN) |-> m_oen && s_oen && !strong_pullup)
        else $error("line not released after reset");
    cover property ($rose(s_oen) && pres);
    cover property ($rose(s_oen) && !pres);
    cover property ($fell(strong_pullup));
endmodule
`default_nettype wire

// ---- test/testbench.sv ----
// self-checking bench joining master and slave ends
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import swl_pkg::*;
    logic       sys_clk = 1'b0;
    logic       rstn = 1'b0;
    logic       ce = 1'b1;
    logic [7:0] rd_val;
    logic       ext_power = 1'b1;
    logic [7:0] temp_lsb = 8'h5a;
    logic [7:0] temp_msb = 8'h81;
    logic [7:0] addr_w = 8'h00;
    logic [1:0] addr = 2'h0;
    logic [7:0] wdata = 8'h00;
    logic       wr = 1'b0;
    logic       rd = 1'b0;
    logic [7:0] rdata;
    logic [7:0] alarm_high;
    logic [7:0] alarm_low;
    logic       conv_busy;
    int         n_errors = 0;
    int         num_checks = 0;
    int         cycles = 0;
    swl_if link ();
    swl_master #(.CONV_CYC(4000)) swl_master_i (.SYS_CLK(sys_clk), .RSTN(rstn), .CE(ce),
        .LINK(link), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata));
    // busy times long enough that the first read slot after a command sees busy
    swl_slave #(.CONV_CYC(3000), .COPY_CYC(3000)) swl_slave_i (.SYS_CLK(sys_clk), .RSTN(rstn),
        .CE(ce), .LINK(link), .EXT_POWER(ext_power), .TEMP_LSB(temp_lsb),
        .TEMP_MSB(temp_msb), .CHECK_BYTE(addr_w), .ALARM_HIGH(alarm_high),
        .ALARM_LOW(alarm_low), .CONV_BUSY(conv_busy));
    swl_monitor #(.CONV_CYC(4000)) swl_monitor_i (.SYS_CLK(sys_clk), .RSTN(rstn),
        .m_oen(link.m_oen), .s_oen(link.s_oen), .strong_pullup(link.strong_pullup),
        .line(link.line));
    // clock; cycle ceiling sized for some 1.4 million cycles of traffic
    always #10 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 2000000) begin
            n_errors++;
            end_sim();
        end
    end
    task automatic end_sim;
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // register port: one-cycle strobes, read data the cycle after
    task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge sys_clk);
        wr    <= 1'b0;
    endtask
    task automatic rd_reg(input logic [1:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge sys_clk);
        rd   <= 1'b0;
        #1 d = rdata;
    endtask
    // ctrl writes are ignored while busy, so wait it out
    task automatic run_op(input logic [1:0] o);
        logic [7:0] s;
        wr_reg(MREG_CTRL, {6'h00, o});
        do rd_reg(MREG_STATUS, s);
        while (s[STAT_BUSY] !== 1'b0);
    endtask
    task automatic send(input logic [7:0] v);
        wr_reg(MREG_TXDATA, v);
        run_op(OP_WBYTE);
    endtask
    task automatic recv(input logic [7:0] exp);
        logic [7:0] v;
        run_op(OP_RBYTE);
        rd_reg(MREG_RXDATA, v);
        check(v, exp);
    endtask
    task automatic start(input logic [7:0] cmd);
        logic [7:0] s;
        run_op(OP_RESET);
        rd_reg(MREG_STATUS, s);
        check({7'h00, s[STAT_PRES]}, 8'h01);
        send(8'hcc);
        send(cmd);
    endtask
    initial begin
        repeat (4) @(posedge sys_clk);
        rstn <= 1'b1;
        repeat (3) @(posedge sys_clk);
        check(alarm_high, NV_HIGH_RESET);
        check(alarm_low, NV_LOW_RESET);
        start(CMD_WRITE_PAD);
        send(8'ha5);
        send(8'h3c);
        check(alarm_high, 8'ha5);
        check(alarm_low, 8'h3c);
        $display("test write_pad done");
        start(CMD_WRITE_PAD);
        send(8'h77);
        start(CMD_READ_PAD);
        check(alarm_low, 8'h3c);
        recv(temp_lsb);
        recv(temp_msb);
        recv(8'h77);
        recv(8'h3c);
        $display("test abort_read done");
        start(CMD_COPY_PAD);
        recv(8'hfe);
        start(CMD_WRITE_PAD);
        send(8'h11);
        send(8'h22);
        start(CMD_RELOAD);
        recv(8'hff);
        check(alarm_high, 8'h77);
        check(alarm_low, 8'h3c);
        $display("test copy_reload done");
        // a write while the clock enable is low must leave no trace
        @(posedge sys_clk);
        ce <= 1'b0;
        wr_reg(MREG_TXDATA, 8'h5c);
        ce <= 1'b1;
        rd_reg(MREG_TXDATA, rd_val);
        check(rd_val, CMD_RELOAD);
        $display("test clock_enable done");
        start(CMD_CONVERT);
        check({7'h00, conv_busy}, 8'h01);
        run_op(OP_HOLD);
        check({7'h00, conv_busy}, 8'h00);
        recv(8'hff);
        @(posedge sys_clk);
        ext_power <= 1'b0;
        start(CMD_SUPPLY);
        recv(8'h00);
        start(8'h99);
        recv(8'hff);
        $display("test convert_supply done");
        end_sim();
    end
endmodule
`default_nettype wire
